/* File: verilog/cip_pkg.sv */
package cip_pkg;
  // Common event register bit positions
  localparam int CMN_TIMER = 0;
  localparam int CMN_ERROR = 1;
  localparam int CMN_LOW = 2;
  localparam int CMN_HIGH = 3;
  localparam int CMN_IDLE = 4;
  localparam int CMN_RX = 5;
  localparam int CMN_TX = 6;
  localparam int CMN_WIDTH = 7;
  // Divided event register bit positions
  localparam int DIV_CRC = 0;
  localparam int DIV_FIELD_ON = 1;
  localparam int DIV_FIELD_OFF = 2;
  localparam int DIV_MODE = 3;
  localparam int DIV_WIDTH = 4;
  // Group masks for the two summary lines
  localparam logic [6:0] CMN_HIGH_MASK = 7'h6c;
  localparam logic [6:0] CMN_LOW_MASK = 7'h13;
  // FIFO geometry
  localparam int FIFO_DEPTH = 64;
  localparam int LEVEL_W = 7;
  localparam int THRESH_W = 6;
  // Command codes
  localparam int CMD_W = 4;
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_NO_CHANGE = 4'h7;
  // Soft power-down exit length in clock cycles
  localparam int PD_EXIT_CYCLES = 1024;
  localparam int PD_CNT_W = 10;
  // Timer and error widths
  localparam int TIMER_W = 16;
  localparam int ERROR_W = 8;
  // Conductance field widths
  localparam int GS_N_W = 4;
  localparam int GS_P_W = 6;
  localparam logic [1:0] DRV_SEL_NONE = 2'h0;
  // Reset values
  localparam logic [3:0] CMD_RESET = 4'h0;
  typedef enum logic [1:0] {CIP_PW_RUN, CIP_PW_SOFT, CIP_PW_EXIT} cip_pw_state_t;
endpackage : cip_pkg

/* File: verilog/cip_sync.sv */
`timescale 1ns/1ps
module cip_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out_ff
);
  logic [WIDTH-1:0] stage1_ff;

  // Both bits reset to zero: no hard power-down and no field during reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_ff <= {WIDTH{1'b0}};
      sync_out_ff <= {WIDTH{1'b0}};
    end else begin
      stage1_ff <= async_in;
      sync_out_ff <= stage1_ff;
    end
  end
endmodule : cip_sync

/* File: verilog/cip_flag_bank.sv */
`timescale 1ns/1ps
module cip_flag_bank #(
  parameter int N = 7
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [N-1:0] hw_set,
  input wire logic sw_wr,
  input wire logic sw_set,
  input wire logic [N-1:0] sw_sel,
  output logic [N-1:0] flags_ff
);
  logic [N-1:0] nxt_flags;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      // Hardware set beats a software clear in the same cycle
      assign nxt_flags[i] = hw_set[i] | ((sw_wr && sw_sel[i]) ? sw_set : flags_ff[i]);
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags_ff <= {N{1'b0}};
    end else begin
      flags_ff <= nxt_flags;
    end
  end
endmodule : cip_flag_bank

/* File: verilog/cip_irq_power.sv */
`timescale 1ns/1ps
// Contract
// - Timer flag sets on count one to zero
// - Transmit flag sets entering end-of-frame
// - Checksum flag sets when checksum done rises
// - Receive flag sets at stream end
// - Idle flag sets when command returns idle
// - Nearly-full flag sets on status rise
// - Nearly-empty flag sets on status rise
// - Field-appeared flag sets on field detect
// - Field-disappeared flag sets on field loss
// - Error flag set while error nonzero
// - Mode-found flag sets on mode detect
// - Group flags into two summary bits
// - Summary interrupts core only when enabled
// - Hard power-down stops all units
// - Power-down bit stops units except detector
// - Soft power-down keeps register contents
// - Field wakes device when wake enabled
// - Exit takes 1024 cycles, bit reads one
// - Force conductance top bits, reads unchanged
// - Driver enables off, receiver stays on
// - Command write starts sequencer execution
// - Firmware may set or clear timer flag
// - Nearly-full when free space at most threshold
// - Nearly-empty when count at most threshold
module cip_irq_power
  import cip_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hard_powerdown_n,
  input wire logic field_detect,
  input wire logic [cip_pkg::TIMER_W-1:0] timer_count,
  input wire logic tx_sending_payload,
  input wire logic tx_sending_eof,
  input wire logic checksum_done_status,
  input wire logic rx_stream_end,
  input wire logic command_done,
  input wire logic [cip_pkg::LEVEL_W-1:0] fifo_level,
  input wire logic [cip_pkg::THRESH_W-1:0] fifo_threshold,
  input wire logic [cip_pkg::ERROR_W-1:0] error_register,
  input wire logic mode_detected,
  input wire logic flag_wr,
  input wire logic flag_wr_set,
  input wire logic [cip_pkg::CMN_WIDTH-1:0] flag_wr_sel_common,
  input wire logic [cip_pkg::DIV_WIDTH-1:0] flag_wr_sel_divided,
  input wire logic high_enable,
  input wire logic low_enable,
  input wire logic cmd_wr,
  input wire logic [cip_pkg::CMD_W-1:0] cmd_wr_code,
  input wire logic cmd_wr_powerdown,
  input wire logic field_wake_enable,
  input wire logic [1:0] driver_select,
  input wire logic antenna_driver1_enable,
  input wire logic antenna_driver2_enable,
  input wire logic [cip_pkg::GS_N_W-1:0] carrier_n_conductance_on,
  input wire logic [cip_pkg::GS_N_W-1:0] carrier_n_conductance_off,
  input wire logic [cip_pkg::GS_N_W-1:0] modulation_n_conductance_on,
  input wire logic [cip_pkg::GS_N_W-1:0] modulation_n_conductance_off,
  input wire logic [cip_pkg::GS_P_W-1:0] carrier_p_conductance,
  input wire logic [cip_pkg::GS_P_W-1:0] modulation_p_conductance,
  output logic [cip_pkg::CMN_WIDTH-1:0] common_event_register,
  output logic [cip_pkg::DIV_WIDTH-1:0] divided_event_register,
  output logic high_priority_summary_ff,
  output logic low_priority_summary_ff,
  output logic irq_high_ff,
  output logic irq_low_ff,
  output logic fifo_nearly_full_status_ff,
  output logic fifo_nearly_empty_status_ff,
  output logic [cip_pkg::CMD_W-1:0] command_code_ff,
  output logic command_start_ff,
  output logic powerdown_bit_ff,
  output logic units_enable_ff,
  output logic field_detector_enable_ff,
  output logic receiver_enable_ff,
  output logic antenna_drive1_ff,
  output logic antenna_drive2_ff,
  output logic [cip_pkg::GS_N_W-1:0] carrier_n_on_drive_ff,
  output logic [cip_pkg::GS_N_W-1:0] carrier_n_off_drive_ff,
  output logic [cip_pkg::GS_N_W-1:0] modulation_n_on_drive_ff,
  output logic [cip_pkg::GS_N_W-1:0] modulation_n_off_drive_ff,
  output logic [cip_pkg::GS_P_W-1:0] carrier_p_drive_ff,
  output logic [cip_pkg::GS_P_W-1:0] modulation_p_drive_ff
);
  import cip_pkg::*;

  logic [1:0] pins_sync;
  logic hard_pd;
  logic field_s;
  cip_pw_state_t pw_state_ff;
  cip_pw_state_t nxt_pw_state;
  logic [PD_CNT_W-1:0] exit_cnt_ff;
  logic [PD_CNT_W-1:0] nxt_exit_cnt;
  logic [TIMER_W-1:0] timer_prev_ff;
  logic tx_payload_prev_ff;
  logic crc_prev_ff;
  logic field_prev_ff;
  logic units_run;
  logic ev_timer, ev_tx, ev_crc, ev_rx, ev_idle, ev_high, ev_low, ev_err, ev_mode;
  logic ev_field_on, ev_field_off;
  logic [LEVEL_W-1:0] free_space;
  logic nxt_full_status, nxt_empty_status;
  logic [CMN_WIDTH-1:0] cmn_set;
  logic [DIV_WIDTH-1:0] div_set;
  logic cmd_takes_code;
  logic force_gs;
  logic wake_req, resume_req;

  cip_sync #(.WIDTH(2)) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({field_detect, ~hard_powerdown_n}),
    .sync_out_ff(pins_sync)
  );

  assign hard_pd = pins_sync[0];
  assign field_s = pins_sync[1] & ~hard_pd;
  assign units_run = ~hard_pd && (pw_state_ff == CIP_PW_RUN);

  // Unit events are ignored while stopped so flags hold their content
  assign ev_timer = units_run && (timer_prev_ff == 16'h0001) && (timer_count == 16'h0000);
  assign ev_tx = units_run && tx_payload_prev_ff && tx_sending_eof;
  assign ev_crc = units_run && checksum_done_status && !crc_prev_ff;
  assign ev_rx = units_run && rx_stream_end;
  assign ev_idle = units_run && command_done && (command_code_ff != CMD_IDLE);
  assign free_space = LEVEL_W'(FIFO_DEPTH) - fifo_level;
  assign nxt_full_status = free_space <= {1'b0, fifo_threshold};
  assign nxt_empty_status = fifo_level <= {1'b0, fifo_threshold};
  assign ev_high = units_run && nxt_full_status && !fifo_nearly_full_status_ff;
  assign ev_low = units_run && nxt_empty_status && !fifo_nearly_empty_status_ff;
  assign ev_err = units_run && (|error_register);
  assign ev_mode = units_run && mode_detected;
  // Field detector keeps running in soft power-down
  assign ev_field_on = field_s && !field_prev_ff;
  assign ev_field_off = !field_s && field_prev_ff && !hard_pd;

  assign cmn_set = {ev_tx, ev_rx, ev_idle, ev_high, ev_low, ev_err, ev_timer};
  assign div_set = {ev_mode, ev_field_off, ev_field_on, ev_crc};

  cip_flag_bank #(.N(CMN_WIDTH)) u_common_flags (
    .clock(clock),
    .rst_n(rst_n),
    .hw_set(cmn_set),
    .sw_wr(flag_wr),
    .sw_set(flag_wr_set),
    .sw_sel(flag_wr_sel_common),
    .flags_ff(common_event_register)
  );

  cip_flag_bank #(.N(DIV_WIDTH)) u_divided_flags (
    .clock(clock),
    .rst_n(rst_n),
    .hw_set(div_set),
    .sw_wr(flag_wr),
    .sw_set(flag_wr_set),
    .sw_sel(flag_wr_sel_divided),
    .flags_ff(divided_event_register)
  );

  // Command field; no-change code only touches the power-down bit
  assign cmd_takes_code = cmd_wr && (cmd_wr_code != CMD_NO_CHANGE) && units_run;
  assign wake_req = field_wake_enable && field_s;
  assign resume_req = cmd_wr && !cmd_wr_powerdown;

  always_comb begin
    nxt_pw_state = pw_state_ff;
    nxt_exit_cnt = exit_cnt_ff;
    case (pw_state_ff)
      CIP_PW_RUN: begin
        if (cmd_wr && cmd_wr_powerdown) begin
          nxt_pw_state = CIP_PW_SOFT;
        end
      end
      CIP_PW_SOFT: begin
        if (resume_req || wake_req) begin
          nxt_pw_state = CIP_PW_EXIT;
          nxt_exit_cnt = '0;
        end
      end
      CIP_PW_EXIT: begin
        // Oscillator settles before units restart
        if (exit_cnt_ff == PD_CNT_W'(PD_EXIT_CYCLES - 1)) begin
          nxt_pw_state = CIP_PW_RUN;
        end else begin
          nxt_exit_cnt = exit_cnt_ff + 1'b1;
        end
      end
      default: begin
        nxt_pw_state = CIP_PW_RUN;
      end
    endcase
  end

  assign force_gs = (pw_state_ff != CIP_PW_RUN) && (driver_select != DRV_SEL_NONE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pw_state_ff <= CIP_PW_RUN;
      exit_cnt_ff <= '0;
      powerdown_bit_ff <= 1'b0;
    end else begin
      pw_state_ff <= nxt_pw_state;
      exit_cnt_ff <= nxt_exit_cnt;
      powerdown_bit_ff <= nxt_pw_state != CIP_PW_RUN;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      command_code_ff <= CMD_RESET;
      command_start_ff <= 1'b0;
    end else begin
      command_start_ff <= cmd_takes_code && (cmd_wr_code != CMD_IDLE);
      if (cmd_takes_code) begin
        command_code_ff <= cmd_wr_code;
      end else if (units_run && command_done) begin
        command_code_ff <= CMD_IDLE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_prev_ff <= '0;
      tx_payload_prev_ff <= 1'b0;
      crc_prev_ff <= 1'b0;
      field_prev_ff <= 1'b0;
      fifo_nearly_full_status_ff <= 1'b0;
      fifo_nearly_empty_status_ff <= 1'b0;
    end else begin
      timer_prev_ff <= timer_count;
      tx_payload_prev_ff <= tx_sending_payload;
      crc_prev_ff <= checksum_done_status;
      field_prev_ff <= field_s;
      fifo_nearly_full_status_ff <= nxt_full_status;
      fifo_nearly_empty_status_ff <= nxt_empty_status;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      high_priority_summary_ff <= 1'b0;
      low_priority_summary_ff <= 1'b0;
      irq_high_ff <= 1'b0;
      irq_low_ff <= 1'b0;
    end else begin
      high_priority_summary_ff <= |(common_event_register & CMN_HIGH_MASK);
      low_priority_summary_ff <= (|(common_event_register & CMN_LOW_MASK))
        || (|divided_event_register);
      irq_high_ff <= high_priority_summary_ff && high_enable;
      irq_low_ff <= low_priority_summary_ff && low_enable;
    end
  end

  // Forced bits reach only the driver stage; register reads stay untouched
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      units_enable_ff <= 1'b0;
      field_detector_enable_ff <= 1'b0;
      receiver_enable_ff <= 1'b0;
      antenna_drive1_ff <= 1'b0;
      antenna_drive2_ff <= 1'b0;
      carrier_n_on_drive_ff <= '0;
      carrier_n_off_drive_ff <= '0;
      modulation_n_on_drive_ff <= '0;
      modulation_n_off_drive_ff <= '0;
      carrier_p_drive_ff <= '0;
      modulation_p_drive_ff <= '0;
    end else begin
      units_enable_ff <= units_run;
      field_detector_enable_ff <= !hard_pd;
      receiver_enable_ff <= units_run;
      antenna_drive1_ff <= units_run && antenna_driver1_enable;
      antenna_drive2_ff <= units_run && antenna_driver2_enable;
      carrier_n_on_drive_ff <= carrier_n_conductance_on | {force_gs, 3'h0};
      carrier_n_off_drive_ff <= carrier_n_conductance_off | {force_gs, 3'h0};
      modulation_n_on_drive_ff <= modulation_n_conductance_on | {force_gs, 3'h0};
      modulation_n_off_drive_ff <= modulation_n_conductance_off | {force_gs, 3'h0};
      carrier_p_drive_ff <= carrier_p_conductance | {force_gs, 5'h00};
      modulation_p_drive_ff <= modulation_p_conductance | {force_gs, 5'h00};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_resume_write;
    (pw_state_ff == CIP_PW_SOFT) && resume_req;
  endsequence
  sequence s_exit_hold;
    powerdown_bit_ff [*8];
  endsequence

  a_timer_flag: assert property (ev_timer |=> common_event_register[CMN_TIMER])
    else $error("timer flag not set on one to zero");
  a_tx_flag: assert property (ev_tx |=> common_event_register[CMN_TX])
    else $error("transmit flag not set at end of frame");
  a_crc_flag: assert property ($rose(checksum_done_status) && units_run
    |=> divided_event_register[DIV_CRC])
    else $error("checksum flag not set");
  a_idle_flag: assert property (ev_idle && !cmd_wr
    |=> common_event_register[CMN_IDLE] && command_code_ff == CMD_IDLE)
    else $error("idle flag or idle code missing");
  a_full_status: assert property (fifo_level == 7'h38 && fifo_threshold == 6'h08
    |=> fifo_nearly_full_status_ff)
    else $error("nearly full status wrong");
  a_empty_status: assert property (fifo_level == 7'h09 && fifo_threshold == 6'h08
    |=> !fifo_nearly_empty_status_ff)
    else $error("nearly empty status wrong");
  a_field_flags: assert property ($rose(field_s) |=> divided_event_register[DIV_FIELD_ON])
    else $error("field appeared flag missing");
  a_error_flag: assert property (units_run && |error_register
    |=> common_event_register[CMN_ERROR])
    else $error("error flag missing");
  a_summary_gate: assert property (common_event_register[CMN_RX] && high_enable
    ##1 high_enable |=> irq_high_ff)
    else $error("high summary did not interrupt");
  a_irq_masked: assert property (!low_enable |=> !irq_low_ff)
    else $error("masked summary interrupted core");
  a_hard_stop: assert property (hard_pd |=> !units_enable_ff && !field_detector_enable_ff)
    else $error("units run in hard power-down");
  a_soft_enter: assert property (pw_state_ff == CIP_PW_RUN && cmd_wr && cmd_wr_powerdown
    |=> powerdown_bit_ff ##1 !units_enable_ff)
    else $error("soft power-down not entered");
  a_soft_hold: assert property (pw_state_ff == CIP_PW_SOFT && !flag_wr
    |=> $stable(common_event_register))
    else $error("flags changed in power-down");
  a_wake_field: assert property (pw_state_ff == CIP_PW_SOFT && wake_req
    |=> pw_state_ff == CIP_PW_EXIT)
    else $error("field did not wake device");
  a_exit_hold: assert property (s_resume_write |=> s_exit_hold)
    else $error("power-down bit cleared early");
  a_exit_length: assert property ($fell(powerdown_bit_ff)
    |-> $past(exit_cnt_ff) == 10'h3ff)
    else $error("exit not 1024 cycles");
  a_force_bits: assert property (force_gs |=> carrier_p_drive_ff[5] && carrier_n_on_drive_ff[3])
    else $error("conductance bits not forced");
  a_rx_alive: assert property (units_run && !antenna_driver1_enable && !antenna_driver2_enable
    |=> receiver_enable_ff && !antenna_drive1_ff && !antenna_drive2_ff)
    else $error("receiver off with drivers");
  a_cmd_start: assert property (cmd_takes_code && cmd_wr_code == 4'hc
    |=> command_start_ff && command_code_ff == 4'hc)
    else $error("command not started");
  a_sticky: assert property (common_event_register[CMN_TIMER] && !flag_wr
    |=> common_event_register[CMN_TIMER])
    else $error("flag lost without clear");
  a_timer_write: assert property (flag_wr && flag_wr_set && flag_wr_sel_common[CMN_TIMER]
    |=> common_event_register[CMN_TIMER])
    else $error("timer flag not writable");
endmodule : cip_irq_power

/* File: verif/cip_core_model.sv */
`timescale 1ns/1ps
module cip_core_model
  import cip_pkg::*;
(
  input wire logic clock,
  output logic flag_wr,
  output logic flag_wr_set,
  output logic [cip_pkg::CMN_WIDTH-1:0] flag_wr_sel_common,
  output logic [cip_pkg::DIV_WIDTH-1:0] flag_wr_sel_divided,
  output logic cmd_wr,
  output logic [cip_pkg::CMD_W-1:0] cmd_wr_code,
  output logic cmd_wr_powerdown
);
  // Strobes last one cycle; fields stay put until the next write
  initial begin
    flag_wr = 1'b0;
    flag_wr_set = 1'b0;
    flag_wr_sel_common = '0;
    flag_wr_sel_divided = '0;
    cmd_wr = 1'b0;
    cmd_wr_code = CMD_IDLE;
    cmd_wr_powerdown = 1'b0;
  end

  task automatic flag_write(input logic set, input logic [6:0] selc, input logic [3:0] seld);
    @(posedge clock);
    flag_wr <= 1'b1;
    flag_wr_set <= set;
    flag_wr_sel_common <= selc;
    flag_wr_sel_divided <= seld;
    @(posedge clock);
    flag_wr <= 1'b0;
  endtask : flag_write

  // Command start by code write
  task automatic cmd_write(input logic [3:0] code, input logic pd);
    @(posedge clock);
    cmd_wr <= 1'b1;
    cmd_wr_code <= code;
    cmd_wr_powerdown <= pd;
    @(posedge clock);
    cmd_wr <= 1'b0;
  endtask : cmd_write
endmodule : cip_core_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import cip_pkg::*;
  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] post;
    logic [6:0] lvl;
    logic [6:0] cmn;
    logic [3:0] div;
  } cip_row_t;
  cip_row_t rows [12];
  int miscompares = 0, n_compared = 0;
  logic clock = 1'b0, rst_n = 1'b0, hard_powerdown_n = 1'b1, field_detect = 1'b0;
  logic [15:0] timer_count = 16'h5;
  logic tx_sending_payload = 1'b0, tx_sending_eof = 1'b0, checksum_done_status = 1'b0;
  logic rx_stream_end = 1'b0, command_done = 1'b0, mode_detected = 1'b0;
  logic [6:0] fifo_level = 7'h20;
  logic [5:0] fifo_threshold = 6'h08;
  logic [7:0] error_register = 8'h0;
  logic high_enable = 1'b1, low_enable = 1'b1, field_wake_enable = 1'b0;
  logic [1:0] driver_select = 2'h0;
  logic antenna_driver1_enable = 1'b1, antenna_driver2_enable = 1'b1;
  logic [3:0] carrier_n_conductance_on = 4'h0, carrier_n_conductance_off = 4'h0;
  logic [3:0] modulation_n_conductance_on = 4'h0, modulation_n_conductance_off = 4'h0;
  logic [5:0] carrier_p_conductance = 6'h0, modulation_p_conductance = 6'h0;
  logic flag_wr, flag_wr_set, cmd_wr, cmd_wr_powerdown;
  logic [6:0] flag_wr_sel_common, common_event_register;
  logic [3:0] flag_wr_sel_divided, cmd_wr_code, divided_event_register, command_code_ff;
  logic high_priority_summary_ff, low_priority_summary_ff, irq_high_ff, irq_low_ff;
  logic fifo_nearly_full_status_ff, fifo_nearly_empty_status_ff, command_start_ff;
  logic powerdown_bit_ff, units_enable_ff, field_detector_enable_ff, receiver_enable_ff;
  logic antenna_drive1_ff, antenna_drive2_ff;
  logic [3:0] carrier_n_on_drive_ff, carrier_n_off_drive_ff;
  logic [3:0] modulation_n_on_drive_ff, modulation_n_off_drive_ff;
  logic [5:0] carrier_p_drive_ff, modulation_p_drive_ff;

  always #12.5 clock = ~clock;

  cip_irq_power cip_irq_power_i (.*);
  cip_core_model cip_core_model_i (.*);

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : cyc

  // One stimulus phase; the timer steps 1 to 0 only when bit 0 is in both phases
  task automatic apply(input logic [7:0] s, input logic [6:0] l, input logic last);
    @(posedge clock);
    timer_count <= s[0] ? {15'h0, !last} : 16'h5;
    tx_sending_payload <= s[1];
    tx_sending_eof <= s[2];
    checksum_done_status <= s[3];
    rx_stream_end <= s[4];
    command_done <= s[5];
    mode_detected <= s[6];
    error_register <= {s[7], 7'h0};
    fifo_level <= l;
  endtask : apply

  task automatic clear_all();
    cip_core_model_i.flag_write(1'b0, 7'h7f, 4'hf);
  endtask : clear_all

  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    rows = '{'{8'h01, 8'h01, 7'h20, 7'h01, 4'h0}, '{8'h00, 8'h01, 7'h20, 7'h00, 4'h0},
             '{8'h02, 8'h04, 7'h20, 7'h40, 4'h0}, '{8'h00, 8'h04, 7'h20, 7'h00, 4'h0},
             '{8'h00, 8'h08, 7'h20, 7'h00, 4'h1}, '{8'h00, 8'h10, 7'h20, 7'h20, 4'h0},
             '{8'h00, 8'h40, 7'h20, 7'h00, 4'h8}, '{8'h00, 8'h80, 7'h20, 7'h02, 4'h0},
             '{8'h00, 8'h00, 7'h38, 7'h08, 4'h0}, '{8'h00, 8'h00, 7'h37, 7'h00, 4'h0},
             '{8'h00, 8'h00, 7'h08, 7'h04, 4'h0}, '{8'h00, 8'h00, 7'h09, 7'h00, 4'h0}};
    cyc(4);
    chk("common", common_event_register, 7'h0);
    chk("divided", divided_event_register, 4'h0);
    chk("pd_bit", powerdown_bit_ff, 1'b0);
    chk("code", command_code_ff, CMD_RESET);
    @(posedge clock);
    rst_n <= 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      apply(rows[i].pre, 7'h20, 1'b0);
      apply(rows[i].post, rows[i].lvl, 1'b1);
      apply(8'h0, 7'h20, 1'b0);
      cyc(4);
      chk("common", common_event_register, rows[i].cmn);
      chk("divided", divided_event_register, rows[i].div);
      chk("hi_sum", high_priority_summary_ff, |(rows[i].cmn & CMN_HIGH_MASK));
      chk("lo_sum", low_priority_summary_ff, |(rows[i].cmn & CMN_LOW_MASK) | |rows[i].div);
      chk("irq_hi", irq_high_ff, |(rows[i].cmn & CMN_HIGH_MASK));
      clear_all();
    end
    // Status follows the level while it is held; flags cleared afterwards
    @(posedge clock);
    fifo_level <= 7'h40;
    cyc(2);
    chk("full", fifo_nearly_full_status_ff, 1'b1);
    chk("empty", fifo_nearly_empty_status_ff, 1'b0);
    @(posedge clock);
    fifo_level <= 7'h00;
    cyc(2);
    chk("full", fifo_nearly_full_status_ff, 1'b0);
    chk("empty", fifo_nearly_empty_status_ff, 1'b1);
    @(posedge clock);
    fifo_level <= 7'h20;
    cyc(2);
    chk("common", common_event_register, 7'h0c);
    clear_all();
    // Masked summary must not reach the core
    @(posedge clock);
    high_enable <= 1'b0;
    apply(8'h10, 7'h20, 1'b1);
    apply(8'h0, 7'h20, 1'b0);
    cyc(4);
    chk("hi_sum", high_priority_summary_ff, 1'b1);
    chk("irq_hi", irq_high_ff, 1'b0);
    chk("irq_lo", irq_low_ff, 1'b0);
    cip_core_model_i.flag_write(1'b1, 7'h01, 4'h0);
    cyc(3);
    chk("common", common_event_register, 7'h21);
    chk("irq_lo", irq_low_ff, 1'b1);
    cip_core_model_i.flag_write(1'b0, 7'h01, 4'h0);
    @(negedge clock);
    chk("common", common_event_register, 7'h20);
    @(posedge clock);
    high_enable <= 1'b1;
    cyc(2);
    chk("irq_hi", irq_high_ff, 1'b1);
    clear_all();
    cip_core_model_i.cmd_write(4'hc, 1'b0);
    @(negedge clock);
    chk("code", command_code_ff, 4'hc);
    chk("start", command_start_ff, 1'b1);
    cip_core_model_i.cmd_write(CMD_NO_CHANGE, 1'b0);
    cyc(1);
    chk("code", command_code_ff, 4'hc);
    apply(8'h20, 7'h20, 1'b1);
    apply(8'h0, 7'h20, 1'b0);
    cyc(3);
    chk("code", command_code_ff, CMD_IDLE);
    chk("common", common_event_register, 7'h10);
    clear_all();
    @(posedge clock);
    field_detect <= 1'b1;
    cyc(5);
    chk("divided", divided_event_register, 4'h2);
    @(posedge clock);
    field_detect <= 1'b0;
    cyc(5);
    chk("divided", divided_event_register, 4'h6);
    clear_all();
    @(posedge clock);
    hard_powerdown_n <= 1'b0;
    cyc(5);
    chk("units", units_enable_ff, 1'b0);
    chk("detector", field_detector_enable_ff, 1'b0);
    chk("receiver", receiver_enable_ff, 1'b0);
    @(posedge clock);
    hard_powerdown_n <= 1'b1;
    driver_select <= 2'h1;
    carrier_n_conductance_on <= 4'h3;
    carrier_n_conductance_off <= 4'h1;
    modulation_n_conductance_on <= 4'h2;
    modulation_n_conductance_off <= 4'h4;
    carrier_p_conductance <= 6'h11;
    modulation_p_conductance <= 6'h05;
    cyc(5);
    chk("cn_on", carrier_n_on_drive_ff, 4'h3);
    cip_core_model_i.flag_write(1'b1, 7'h01, 4'h0);
    cip_core_model_i.cmd_write(CMD_NO_CHANGE, 1'b1);
    @(negedge clock);
    chk("pd_bit", powerdown_bit_ff, 1'b1);
    cyc(2);
    chk("units", units_enable_ff, 1'b0);
    chk("detector", field_detector_enable_ff, 1'b1);
    chk("cn_on", carrier_n_on_drive_ff, 4'hb);
    chk("mp", modulation_p_drive_ff, 6'h25);
    chk("cn_off", carrier_n_off_drive_ff, 4'h9);
    chk("mn_on", modulation_n_on_drive_ff, 4'ha);
    chk("mn_off", modulation_n_off_drive_ff, 4'hc);
    chk("cp", carrier_p_drive_ff, 6'h31);
    apply(8'h10, 7'h20, 1'b1);
    apply(8'h0, 7'h20, 1'b0);
    cyc(3);
    chk("common", common_event_register, 7'h01);
    cip_core_model_i.cmd_write(CMD_NO_CHANGE, 1'b0);
    cyc(1023);
    chk("pd_bit", powerdown_bit_ff, 1'b1);
    cyc(1);
    chk("pd_bit", powerdown_bit_ff, 1'b0);
    cyc(2);
    chk("units", units_enable_ff, 1'b1);
    chk("cn_on", carrier_n_on_drive_ff, 4'h3);
    chk("drive1", antenna_drive1_ff, 1'b1);
    // No initial-field-on pending here, so the enables may simply drop
    @(posedge clock);
    antenna_driver1_enable <= 1'b0;
    antenna_driver2_enable <= 1'b0;
    cyc(3);
    chk("drive1", antenna_drive1_ff, 1'b0);
    chk("drive2", antenna_drive2_ff, 1'b0);
    chk("receiver", receiver_enable_ff, 1'b1);
    @(posedge clock);
    field_wake_enable <= 1'b1;
    cip_core_model_i.cmd_write(CMD_NO_CHANGE, 1'b1);
    @(posedge clock);
    field_detect <= 1'b1;
    cyc(1000);
    chk("pd_bit", powerdown_bit_ff, 1'b1);
    cyc(40);
    chk("pd_bit", powerdown_bit_ff, 1'b0);
    chk("divided", divided_event_register, 4'h2);
    // Reset in mid-run wipes the sticky flags and the summaries
    @(posedge clock);
    rst_n <= 1'b0;
    cyc(2);
    chk("common", common_event_register, 7'h0);
    chk("divided", divided_event_register, 4'h0);
    chk("lo_sum", low_priority_summary_ff, 1'b0);
    chk("pd_bit", powerdown_bit_ff, 1'b0);
    conclude();
  end
endmodule : tb
